//--- src/cmb_message_buffering.sv
`timescale 1ns/1ps
module cmb_message_buffering (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata,
	input  wire logic        bus_receive_pin,
	output logic             bus_transmit_pin,
	input  wire logic        pe_tx_bit,
	output logic             rx_bit,
	input  wire logic        pe_rx_wr,
	input  wire logic [3:0]  pe_rx_idx,
	input  wire logic [7:0]  pe_rx_data,
	input  wire logic        pe_rx_eof,
	input  wire logic        pe_rx_hit,
	output logic             rx_ack_enable,
	input  wire logic        pe_arb_start,
	input  wire logic        pe_tx_done,
	input  wire logic        pe_tx_fail,
	input  wire logic [3:0]  pe_tx_idx,
	output logic             tx_pending,
	output logic             tx_active,
	output logic [7:0]       tx_data,
	output logic             rx_irq,
	output logic             tx_irq,
	output logic             err_irq
);

	// How the block is worked, for whoever integrates it.
	// The protocol engine owns bit timing, framing, stuffing and the acceptance filter.
	// This block only stores frames and decides which stored frame goes out next.
	// Receive path:
	// Every received byte lands in the background buffer at the index the engine gives.
	// Indices above twelve are ignored, so a long frame cannot spill into other state.
	// At a good end of frame the filter verdict decides whether the frame moves up.
	// A frame we send ourselves is never moved up outside loop-back.
	// The foreground buffer is the only receive storage software can read.
	// When the foreground is still full, an accepted frame waits in the background.
	// While it waits, the background stops taking bytes so the waiting frame survives.
	// A third accepted frame in that state is dropped and the overrun flag is set.
	// Freeing the foreground moves the waiting frame up in the same cycle, or one cycle later if an accepted frame ends in that cycle.
	// Receive-full therefore stays high across that clear, or is low for that one cycle, which software must expect.
	// Transmit path:
	// Each of the three buffers is loaded while its empty flag is set.
	// Writes to a buffer that is scheduled are dropped, so a frame cannot change mid-send.
	// Clearing the empty flag schedules the buffer.
	// At each arbitration start the scheduled buffer with the smallest priority is picked.
	// Equal priorities go to the lower buffer number, which keeps the choice repeatable.
	// A failed attempt only drops the selection; the next start picks again.
	// So a buffer scheduled during a retry can overtake the one that failed.
	// A good send sets the empty flag again and clears that buffer's abort state.
	// Abort requests:
	// A request is held until the buffer is either sent or cancelled.
	// A buffer that is not the one on the bus is cancelled one cycle after the request.
	// The buffer on the bus keeps its request until it ends.
	// Abort-ack then tells software which of the two outcomes happened.
	// Register bus:
	// The slave never inserts wait states and always answers OKAY.
	// Read data is taken at the address phase and stands through the data phase.
	// Write data is taken in the data phase, so a write shows one cycle later.
	// Unmapped words read as zero and ignore writes.
	// Pins:
	// The receive pin passes two flip-flops before anything reads it.
	// In loop-back the transmit pin stays recessive and the engine hears its own bits.
	// Interrupt outputs are registered levels of their flags masked by the enables.

	typedef logic [cmb_pkg::BUF_BYTES-1:0][7:0] cmb_buf_t;

	typedef struct packed {
		cmb_buf_t                              bg;
		cmb_buf_t                              fg;
		logic [cmb_pkg::NUM_TX-1:0][cmb_pkg::BUF_BYTES-1:0][7:0] txb;
		logic [cmb_pkg::NUM_TX-1:0][7:0]       local_priority_field;
		logic                                  bg_held;
		logic                                  rx_full_flag;
		logic                                  ovr;
		logic                                  rxf_ie;
		logic                                  ovr_ie;
		logic                                  loopback;
		logic [cmb_pkg::NUM_TX-1:0]            tx_empty_flag;
		logic [cmb_pkg::NUM_TX-1:0]            abt_rq;
		logic [cmb_pkg::NUM_TX-1:0]            abt_ak;
		logic [cmb_pkg::NUM_TX-1:0]            txe_ie;
		logic                                  tx_act;
		logic [1:0]                            tx_cur;
		logic                                  dp_wr;
		logic [7:0]                            dp_word;
		logic [31:0]                           rdata;
		logic [7:0]                            tx_data;
		logic                                  rx_s1;
		logic                                  rx_s2;
		logic                                  txpin;
		logic                                  rx_irq;
		logic                                  tx_irq;
		logic                                  err_irq;
	} cmb_state_s;

	cmb_state_s s;
	cmb_state_s next_s;

	// Packs word w of a thirteen-byte buffer, little-endian; missing bytes read as zero.
	function automatic logic [31:0] buf_word(input cmb_buf_t b, input logic [1:0] w);
		logic [31:0] r;
		r = 32'h0000_0000;
		for (int k = 0; k < 4; k++) begin
			if (4 * int'(w) + k < cmb_pkg::BUF_BYTES) begin
				r[8*k +: 8] = b[4 * int'(w) + k];
			end
		end
		return r;
	endfunction

	// Word index of a byte offset.
	function automatic logic [7:0] widx(input logic [9:0] ofs);
		return ofs[9:2];
	endfunction

	// Block index of a sixteen-byte buffer window, to compare with word index bits [7:2].
	function automatic logic [5:0] blk(input logic [9:0] ofs);
		return ofs[9:4];
	endfunction

	// Picks the pending buffer with the lowest priority value; ties go to the lower index.
	function automatic logic [1:0] pick_tx(input logic [cmb_pkg::NUM_TX-1:0] pend,
			input logic [cmb_pkg::NUM_TX-1:0][7:0] pr);
		logic [1:0] best;
		logic       found;
		best  = 2'h0;
		found = 1'b0;
		for (int i = 0; i < cmb_pkg::NUM_TX; i++) begin
			if (pend[i] && (!found || pr[i] < pr[best])) begin
				best  = 2'(i);
				found = 1'b1;
			end
		end
		return best;
	endfunction

	logic        addr_ok;
	logic [7:0]  a_word;
	logic        own_frame;
	logic [31:0] rd;

	assign addr_ok = hsel && hready && htrans[1] && (haddr[31:10] == 22'h000000);
	assign a_word  = haddr[9:2];

	// Bus handshake: every transfer completes with zero wait states and an OKAY answer.
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = s.rdata;

	// A frame is our own only while transmitting outside loop-back; a lost arbitration
	// has already dropped tx_act, so the winning frame is received as foreign.
	assign own_frame     = s.tx_act && !s.loopback;
	assign rx_ack_enable = !own_frame;
	assign tx_pending    = |(~s.tx_empty_flag);
	assign tx_active     = s.tx_act;
	assign tx_data       = s.tx_data;
	assign rx_bit        = s.loopback ? pe_tx_bit : s.rx_s2;
	assign bus_transmit_pin = s.txpin;
	assign rx_irq        = s.rx_irq;
	assign tx_irq        = s.tx_irq;
	assign err_irq       = s.err_irq;

	// Read data for the address phase, registered for the data phase.
	always_comb begin
		rd = 32'h0000_0000;
		if (a_word == widx(cmb_pkg::OFS_RX_FLAG)) begin
			rd[cmb_pkg::RXF_BIT]    = s.rx_full_flag;
			rd[cmb_pkg::OVR_BIT]    = s.ovr;
			rd[cmb_pkg::RXF_IE_BIT] = s.rxf_ie;
			rd[cmb_pkg::OVR_IE_BIT] = s.ovr_ie;
		end else if (a_word == widx(cmb_pkg::OFS_TX_FLAG)) begin
			rd[cmb_pkg::TXE_LSB +: cmb_pkg::NUM_TX]    = s.tx_empty_flag;
			rd[cmb_pkg::ABT_AK_LSB +: cmb_pkg::NUM_TX] = s.abt_ak;
		end else if (a_word == widx(cmb_pkg::OFS_TX_CTRL)) begin
			rd[cmb_pkg::ABT_RQ_LSB +: cmb_pkg::NUM_TX] = s.abt_rq;
			rd[cmb_pkg::TXE_IE_LSB +: cmb_pkg::NUM_TX] = s.txe_ie;
		end else if (a_word == widx(cmb_pkg::OFS_MOD_CTRL1)) begin
			rd[cmb_pkg::LOOPBACK_BIT] = s.loopback;
		end else if (a_word == widx(cmb_pkg::OFS_STATUS)) begin
			rd[cmb_pkg::ACT_BIT]     = s.tx_act;
			rd[cmb_pkg::CUR_LSB +: 2] = s.tx_cur;
			rd[cmb_pkg::BG_HELD_BIT] = s.bg_held;
		end else if (a_word[7:2] == blk(cmb_pkg::OFS_FG_BASE)) begin
			rd = buf_word(s.fg, a_word[1:0]);
		end else begin
			for (int i = 0; i < cmb_pkg::NUM_TX; i++) begin
				if (a_word[7:2] == blk(10'(cmb_pkg::OFS_TX_BASE + 10'(i) * cmb_pkg::OFS_TX_STRIDE))) begin
					rd = buf_word(s.txb[i], a_word[1:0]);
					if (a_word[1:0] == 2'h3) begin
						rd[cmb_pkg::LOCAL_PRIORITY_FIELD_LSB +: 8] = s.local_priority_field[i];
					end
				end
			end
		end
	end

	// Next-state logic: bus writes first, hardware events after, so a hardware event wins over a bus write.
	always_comb begin
		logic [cmb_pkg::NUM_TX-1:0] pend;
		logic [7:0]                 w;
		next_s = s;
		pend   = '0;
		w      = s.dp_word;

		// Pin side: two-stage synchroniser in, registered transmit level out.
		next_s.rx_s1 = bus_receive_pin;
		next_s.rx_s2 = s.rx_s1;
		next_s.txpin = s.loopback ? cmb_pkg::RECESSIVE : pe_tx_bit;

		// Address phase capture.
		next_s.dp_wr   = addr_ok && hwrite;
		next_s.dp_word = a_word;
		if (addr_ok && !hwrite) begin
			next_s.rdata = rd;
		end

		// Data phase writes.
		if (s.dp_wr) begin
			if (w == widx(cmb_pkg::OFS_RX_FLAG)) begin
				if (hwdata[cmb_pkg::RXF_BIT]) begin
					next_s.rx_full_flag = 1'b0;
				end
				if (hwdata[cmb_pkg::OVR_BIT]) begin
					next_s.ovr = 1'b0;
				end
				next_s.rxf_ie = hwdata[cmb_pkg::RXF_IE_BIT];
				next_s.ovr_ie = hwdata[cmb_pkg::OVR_IE_BIT];
			end else if (w == widx(cmb_pkg::OFS_TX_FLAG)) begin
				for (int i = 0; i < cmb_pkg::NUM_TX; i++) begin
					if (hwdata[cmb_pkg::TXE_LSB + i] && s.tx_empty_flag[i]) begin
						next_s.tx_empty_flag[i]    = 1'b0;
						next_s.abt_ak[i] = 1'b0;
					end
				end
			end else if (w == widx(cmb_pkg::OFS_TX_CTRL)) begin
				for (int i = 0; i < cmb_pkg::NUM_TX; i++) begin
					if (hwdata[cmb_pkg::ABT_RQ_LSB + i] && !s.tx_empty_flag[i]) begin
						next_s.abt_rq[i] = 1'b1;
					end
				end
				next_s.txe_ie = hwdata[cmb_pkg::TXE_IE_LSB +: cmb_pkg::NUM_TX];
			end else if (w == widx(cmb_pkg::OFS_MOD_CTRL1)) begin
				next_s.loopback = hwdata[cmb_pkg::LOOPBACK_BIT];
			end else begin
				// Buffer contents and priority are only writable while the buffer is empty.
				for (int i = 0; i < cmb_pkg::NUM_TX; i++) begin
					if (w[7:2] == blk(10'(cmb_pkg::OFS_TX_BASE + 10'(i) * cmb_pkg::OFS_TX_STRIDE))
							&& s.tx_empty_flag[i]) begin
						for (int k = 0; k < 4; k++) begin
							if (4 * int'(w[1:0]) + k < cmb_pkg::BUF_BYTES) begin
								next_s.txb[i][4 * int'(w[1:0]) + k] = hwdata[8*k +: 8];
							end
						end
						if (w[1:0] == 2'h3) begin
							next_s.local_priority_field[i] = hwdata[cmb_pkg::LOCAL_PRIORITY_FIELD_LSB +: 8];
						end
					end
				end
			end
		end

		// Background buffer takes every frame byte unless it holds a frame awaiting copy.
		if (pe_rx_wr && !s.bg_held && pe_rx_idx <= cmb_pkg::LAST_INDEX) begin
			next_s.bg[pe_rx_idx] = pe_rx_data;
		end

		// End of a correct frame: route by filter result and buffer occupancy.
		if (pe_rx_eof && pe_rx_hit && !own_frame) begin
			if (s.bg_held) begin
				next_s.ovr = 1'b1;
			end else if (!next_s.rx_full_flag) begin
				next_s.fg  = s.bg;
				next_s.rx_full_flag = 1'b1;
			end else begin
				next_s.bg_held = 1'b1;
			end
		end else if (s.bg_held && !next_s.rx_full_flag) begin
			// The held frame moves up as soon as the foreground is freed, unless an accepted frame ends in that same cycle.
			next_s.fg      = s.bg;
			next_s.rx_full_flag     = 1'b1;
			next_s.bg_held = 1'b0;
		end

		// End of the frame being sent, or a failed attempt that will arbitrate again.
		if (s.tx_act && pe_tx_done) begin
			next_s.tx_empty_flag[s.tx_cur]    = 1'b1;
			next_s.abt_ak[s.tx_cur] = 1'b0;
			next_s.abt_rq[s.tx_cur] = 1'b0;
			next_s.tx_act           = 1'b0;
		end else if (s.tx_act && pe_tx_fail) begin
			next_s.tx_act = 1'b0;
		end

		// Aborts are granted for every pending buffer that is not on the bus.
		for (int i = 0; i < cmb_pkg::NUM_TX; i++) begin
			if (s.abt_rq[i] && !s.tx_empty_flag[i] && !(s.tx_act && s.tx_cur == 2'(i))) begin
				next_s.tx_empty_flag[i]    = 1'b1;
				next_s.abt_ak[i] = 1'b1;
				next_s.abt_rq[i] = 1'b0;
			end
		end

		// Scheduling at every arbitration, using the latest pending set.
		pend = ~next_s.tx_empty_flag;
		if (pe_arb_start && !s.tx_act && (|pend)) begin
			next_s.tx_act = 1'b1;
			next_s.tx_cur = pick_tx(pend, next_s.local_priority_field);
		end

		// Transmit byte fetch for the protocol engine.
		if (pe_tx_idx <= cmb_pkg::LAST_INDEX) begin
			next_s.tx_data = s.txb[s.tx_cur][pe_tx_idx];
		end else begin
			next_s.tx_data = 8'h00;
		end

		// Interrupt levels follow their flags gated by the enables.
		next_s.rx_irq  = next_s.rx_full_flag && next_s.rxf_ie;
		next_s.tx_irq  = |(next_s.tx_empty_flag & next_s.txe_ie);
		next_s.err_irq = next_s.ovr && next_s.ovr_ie;
	end

	// State register.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s          <= '0;
			s.tx_empty_flag      <= cmb_pkg::TXE_RESET;
			s.txpin    <= cmb_pkg::RECESSIVE;
			s.rx_s1    <= cmb_pkg::RECESSIVE;
			s.rx_s2    <= cmb_pkg::RECESSIVE;
		end else begin
			s <= next_s;
		end
	end

endmodule

//--- src/cmb_pkg.sv
package cmb_pkg;

	// Byte offsets of the register map on the bus.
	localparam logic [9:0] OFS_RX_FLAG   = 10'h000;
	localparam logic [9:0] OFS_TX_FLAG   = 10'h004;
	localparam logic [9:0] OFS_TX_CTRL   = 10'h008;
	localparam logic [9:0] OFS_MOD_CTRL1 = 10'h00c;
	localparam logic [9:0] OFS_STATUS    = 10'h010;
	localparam logic [9:0] OFS_FG_BASE   = 10'h040;
	localparam logic [9:0] OFS_TX_BASE   = 10'h080;
	localparam logic [9:0] OFS_TX_STRIDE = 10'h010;

	// Geometry of one message buffer.
	localparam int         BUF_BYTES  = 13;
	localparam int         BUF_WORDS  = 4;
	localparam int         NUM_TX     = 3;
	localparam logic [3:0] LAST_INDEX = 4'hc;

	// Receive flag register fields.
	localparam int RXF_BIT    = 0;
	localparam int OVR_BIT    = 1;
	localparam int RXF_IE_BIT = 2;
	localparam int OVR_IE_BIT = 3;

	// Transmit flag and control register fields.
	localparam int TXE_LSB    = 0;
	localparam int ABT_AK_LSB = 4;
	localparam int ABT_RQ_LSB = 0;
	localparam int TXE_IE_LSB = 4;

	// Module control one fields.
	localparam int LOOPBACK_BIT = 0;

	// Status register fields.
	localparam int ACT_BIT     = 0;
	localparam int CUR_LSB     = 1;
	localparam int BG_HELD_BIT = 3;

	// Priority byte position inside the last word of a transmit buffer.
	localparam int LOCAL_PRIORITY_FIELD_LSB = 8;

	// Reset values.
	localparam logic [2:0] TXE_RESET = 3'h7;
	localparam logic       RECESSIVE = 1'h1;

endpackage

//--- tb/cmb_can_node.sv
`timescale 1ns/1ps
// Transceiver plus the other nodes: a wired-AND line seen back after a delay.
module cmb_can_node #(
	parameter int DLY = 2
) (
	input  wire logic clk,
	input  wire logic tx_pin,
	input  wire logic other_dom,
	output logic      rx_pin
);
	logic [7:0] line = 8'hff;

	// Any dominant driver pulls the line low, otherwise the termination keeps it recessive.
	always_ff @(posedge clk) begin
		line <= {line[6:0], tx_pin & !other_dom};
	end
	assign rx_pin = line[DLY];
endmodule

//--- tb/cmb_message_buffering_chk.sv
`timescale 1ns/1ps
module cmb_message_buffering_chk (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic bus_receive_pin,
	input wire logic bus_transmit_pin,
	input wire logic pe_tx_bit,
	input wire logic rx_bit,
	input wire logic rx_ack_enable,
	input wire logic pe_arb_start,
	input wire logic pe_tx_done,
	input wire logic pe_tx_fail,
	input wire logic tx_pending,
	input wire logic tx_active
);
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);

	// An arbitration start that must select a buffer.
	sequence s_arb;
		pe_arb_start && !tx_active && tx_pending;
	endsequence
	// The engine ends the transmission, sent or lost.
	sequence s_end;
		pe_tx_done || pe_tx_fail;
	endsequence

	a_pin_low_cause: assert property (!bus_transmit_pin |-> !$past(pe_tx_bit))
		else $error("transmit pin dominant without a dominant bit");
	a_rx_bit_source: assert property ($past(hresetn, 3) |-> rx_bit == $past(bus_receive_pin, 2) || rx_bit == pe_tx_bit)
		else $error("receive bit from neither pin nor loop");
	a_ack_when_idle: assert property (!tx_active |-> rx_ack_enable)
		else $error("acknowledge blocked while not sending");
	a_arb_selects: assert property (s_arb |=> tx_active)
		else $error("no buffer selected at arbitration");
	a_active_cause: assert property ($rose(tx_active) |-> $past(pe_arb_start) && $past(tx_pending))
		else $error("transmission began without arbitration");
	a_end_releases: assert property (s_end |=> !tx_active)
		else $error("buffer still selected after end of transmission");
	a_reset_recessive: assert property ($rose(hresetn) |-> bus_transmit_pin && !tx_active && !tx_pending)
		else $error("wrong state after reset");
	a_bus_okay: assert property (hreadyout && !hresp)
		else $error("bus slave not ready or not okay");
endmodule

bind cmb_message_buffering cmb_message_buffering_chk u_chk (.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout),
	.hresp(hresp), .bus_receive_pin(bus_receive_pin), .bus_transmit_pin(bus_transmit_pin), .pe_tx_bit(pe_tx_bit),
	.rx_bit(rx_bit), .rx_ack_enable(rx_ack_enable), .pe_arb_start(pe_arb_start), .pe_tx_done(pe_tx_done),
	.pe_tx_fail(pe_tx_fail), .tx_pending(tx_pending), .tx_active(tx_active));

//--- tb/tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin failures++; $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready, hreadyout, hresp, rd_phase = 0;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, ex, expq[$];
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic        bus_receive_pin, bus_transmit_pin, rx_bit, rx_ack_enable, tx_pending, tx_active;
	logic        pe_tx_bit = 1, pe_rx_wr = 0, pe_rx_eof = 0, pe_rx_hit = 0, other_dom = 0;
	logic        pe_arb_start = 0, pe_tx_done = 0, pe_tx_fail = 0, rx_irq, tx_irq, err_irq;
	logic [3:0]  pe_rx_idx = 0, pe_tx_idx = 4'hc;
	logic [7:0]  pe_rx_data = 0, tx_data, fb[3][13], t12[3], pr[3] = '{8'h30, 8'h10, 8'h20};
	logic [15:0] lf = 16'd26083;
	int          failures = 0, num_checks = 0;

	assign hready = hreadyout;
	always #2 hclk = ~hclk;

	cmb_message_buffering DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .bus_receive_pin(bus_receive_pin), .bus_transmit_pin(bus_transmit_pin),
		.pe_tx_bit(pe_tx_bit), .rx_bit(rx_bit), .pe_rx_wr(pe_rx_wr), .pe_rx_idx(pe_rx_idx),
		.pe_rx_data(pe_rx_data), .pe_rx_eof(pe_rx_eof), .pe_rx_hit(pe_rx_hit), .rx_ack_enable(rx_ack_enable),
		.pe_arb_start(pe_arb_start), .pe_tx_done(pe_tx_done), .pe_tx_fail(pe_tx_fail), .pe_tx_idx(pe_tx_idx),
		.tx_pending(tx_pending), .tx_active(tx_active), .tx_data(tx_data), .rx_irq(rx_irq), .tx_irq(tx_irq),
		.err_irq(err_irq));
	cmb_can_node #(.DLY(2)) u_node (.clk(hclk), .tx_pin(bus_transmit_pin), .other_dom(other_dom),
		.rx_pin(bus_receive_pin));

	// Read data is compared at the end of its data phase with the oldest note.
	always @(posedge hclk) begin
		if (rd_phase) begin
			ex = expq.pop_front();
			`CHK("hrdata", ex, hrdata)
		end
		rd_phase <= hsel && htrans[1] && !hwrite && hreadyout;
	end

	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	function automatic logic [31:0] fgw(input int k, input int j);
		return j < 3 ? {fb[k][4*j+3], fb[k][4*j+2], fb[k][4*j+1], fb[k][4*j]} : {24'h0, fb[k][12]};
	endfunction

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	// One single word transfer; a read leaves its expected word as a note.
	task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [31:0] e);
		int n;
		n = 0;
		if (!w) expq.push_back(e);
		hsel <= 1;
		haddr <= {22'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
		if (n >= 50) begin failures++; report_and_stop(); end
	endtask

	// Engine delivers frame k byte by byte, then end of frame with the filter verdict.
	task automatic rx_frame(input int k, input logic hit);
		for (int i = 0; i < 13; i++) begin
			pe_rx_wr <= 1;
			pe_rx_idx <= 4'(i);
			pe_rx_data <= fb[k][i];
			@(posedge hclk);
		end
		pe_rx_wr <= 0;
		@(posedge hclk);
		pe_rx_eof <= 1;
		pe_rx_hit <= hit;
		@(posedge hclk);
		pe_rx_eof <= 0;
		pe_rx_hit <= 0;
		repeat (2) @(posedge hclk);
	endtask

	// Pulses arbitration start (0), transmit done (1) or transmit fail (2).
	task automatic pe_pulse(input int c);
		pe_arb_start <= (c == 0);
		pe_tx_done <= (c == 1);
		pe_tx_fail <= (c == 2);
		@(posedge hclk);
		{pe_arb_start, pe_tx_done, pe_tx_fail} <= 3'h0;
		@(posedge hclk);
	endtask

	// Main sequence: reset state, wire, receive FIFO, transmit scheduling, loop-back.
	initial begin
		for (int k = 0; k < 3; k++) begin
			for (int i = 0; i < 14; i++) begin
				lf = lfsr(lf);
				if (i < 13) fb[k][i] = lf[7:0];
				else t12[k] = lf[7:0];
			end
		end
		repeat (5) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		`CHK("pin", 1'b1, bus_transmit_pin)
		xfer(0, cmb_pkg::OFS_TX_FLAG, 0, 32'h7);
		xfer(0, cmb_pkg::OFS_RX_FLAG, 0, 32'h0);
		pe_tx_bit <= 0;
		repeat (8) @(posedge hclk);
		`CHK("pin", 1'b0, bus_transmit_pin)
		`CHK("rx_bit", 1'b0, rx_bit)
		pe_tx_bit <= 1;
		other_dom <= 1;
		repeat (8) @(posedge hclk);
		`CHK("rx_bit", 1'b0, rx_bit)
		other_dom <= 0;
		xfer(1, cmb_pkg::OFS_RX_FLAG, 32'hc, 0);
		rx_frame(0, 0);
		xfer(0, cmb_pkg::OFS_RX_FLAG, 0, 32'hc);
		rx_frame(1, 1);
		`CHK("rx_irq", 1'b1, rx_irq)
		for (int j = 0; j < 4; j++) xfer(0, cmb_pkg::OFS_FG_BASE + 10'(4 * j), 0, fgw(1, j));
		rx_frame(2, 1);
		xfer(0, cmb_pkg::OFS_FG_BASE, 0, fgw(1, 0));
		rx_frame(0, 1);
		`CHK("err_irq", 1'b1, err_irq)
		xfer(1, cmb_pkg::OFS_RX_FLAG, 32'hd, 0);
		xfer(0, cmb_pkg::OFS_RX_FLAG, 0, 32'hf);
		for (int j = 0; j < 4; j++) xfer(0, cmb_pkg::OFS_FG_BASE + 10'(4 * j), 0, fgw(2, j));
		xfer(1, cmb_pkg::OFS_RX_FLAG, 32'hf, 0);
		xfer(0, cmb_pkg::OFS_RX_FLAG, 0, 32'hc);
		for (int k = 0; k < 3; k++)
			xfer(1, cmb_pkg::OFS_TX_BASE + 10'(k) * cmb_pkg::OFS_TX_STRIDE + 10'hc, {16'h0, pr[k], t12[k]}, 0);
		xfer(1, cmb_pkg::OFS_TX_CTRL, 32'h70, 0);
		xfer(1, cmb_pkg::OFS_TX_FLAG, 32'h5, 0);
		pe_pulse(0);
		xfer(0, cmb_pkg::OFS_STATUS, 0, 32'h5);
		`CHK("tx_data", t12[2], tx_data)
		rx_frame(1, 1);
		`CHK("ack", 1'b0, rx_ack_enable)
		xfer(0, cmb_pkg::OFS_RX_FLAG, 0, 32'hc);
		pe_pulse(2);
		xfer(1, cmb_pkg::OFS_TX_FLAG, 32'h2, 0);
		pe_pulse(0);
		xfer(0, cmb_pkg::OFS_STATUS, 0, 32'h3);
		xfer(1, cmb_pkg::OFS_TX_CTRL, 32'h76, 0);
		@(posedge hclk);
		xfer(0, cmb_pkg::OFS_TX_FLAG, 0, 32'h44);
		pe_pulse(1);
		xfer(0, cmb_pkg::OFS_TX_FLAG, 0, 32'h46);
		`CHK("tx_irq", 1'b1, tx_irq)
		pe_pulse(0);
		pe_pulse(1);
		xfer(0, cmb_pkg::OFS_TX_FLAG, 0, 32'h47);
		xfer(1, cmb_pkg::OFS_MOD_CTRL1, 32'h1, 0);
		pe_tx_bit <= 0;
		repeat (3) @(posedge hclk);
		`CHK("pin", 1'b1, bus_transmit_pin)
		`CHK("rx_bit", 1'b0, rx_bit)
		pe_tx_bit <= 1;
		xfer(0, 10'h3fc, 0, 32'h0);
		repeat (3) @(posedge hclk);
		report_and_stop();
	end
endmodule
